// ---- hw/cpu_mul_neg_stack_ops.sv ----
// Execution unit for store, multiply, negate, no-op and return stack push/pop
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Access bit 0 selects access bank; 1 uses bank select register.
// - Access bit 0 with extended set and operand <=95 uses indexed offset.
// - Store opcode copies working register into the selected file register.
// - Literal multiply: unsigned working register times literal, W unchanged.
// - Literal product goes high byte to product_high, low to product_low.
// - File multiply: unsigned working register times selected file register.
// - File multiply stores product pair; W and file register untouched.
// - Multiplies change no status flag, zero product included.
// - Negate replaces file register with inverted value plus one.
// - Negate result goes back to the same file location only.
// - Negate updates negative, overflow, carry, digit carry and zero flags.
// - Pop opcode discards top of stack; entry beneath becomes top.
// - Pop acts in third phase; second and fourth phases idle.
// - Push opcode puts program counter plus two on top of stack.
// - Push moves previous top one level down, still retrievable.
module cpu_mul_neg_stack_ops
  import cpu_ops_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [20:0] pc,
  input  wire logic [7:0]  work_reg,
  input  wire logic [7:0]  bank_select_register,
  input  wire logic [11:0] index_base,
  input  wire logic        ext_set_en,
  input  wire logic [7:0]  file_rdata,
  output logic             ready,
  output logic             done,
  output logic [11:0]      file_addr,
  output logic             file_rd,
  output logic             file_wr,
  output logic [7:0]       file_wdata,
  output logic             indexed_mode,
  output logic [7:0]       product_high,
  output logic [7:0]       product_low,
  output flags_t           flags,
  output logic             flags_wr,
  output logic [20:0]      top_of_stack,
  output logic [4:0]       stack_ptr,
  output logic             stack_overflow,
  output logic             stack_underflow
);

  state_t      st_ff;
  state_t      nxt_st;
  logic        stk_wr;
  logic [4:0]  stk_rd_addr;
  logic [20:0] stk_rd_data;
  logic [15:0] product;
  logic        take;

  function automatic op_t classify(input logic [15:0] w);
    op_t r;
    r = OP_NOP;
    if (w[15:9] == OPC_STORE_HI) begin
      r = OP_STORE;
    end else if (w[15:9] == OPC_NEG_HI) begin
      r = OP_NEG;
    end else if (w[15:9] == OPC_MULF_HI) begin
      r = OP_MULF;
    end else if (w[15:8] == OPC_MULL_HI) begin
      r = OP_MULL;
    end else if (w == OPC_POP) begin
      r = OP_POP;
    end else if (w == OPC_PUSH) begin
      r = OP_PUSH;
    end
    return r;
  endfunction

  function automatic logic [11:0] map_addr(input logic a, input logic [7:0] f,
                                           input logic [7:0] bank, input logic ext,
                                           input logic [11:0] base);
    logic [11:0] r;
    r = {bank[3:0], f};
    if (!a && ext && f <= INDEXED_LIMIT) begin
      r = base + {4'h0, f};
    end else if (!a) begin
      if (f < (ext ? ACCESS_SPLIT_X : ACCESS_SPLIT)) begin
        r = {ACCESS_LO_BANK, f};
      end else begin
        r = {ACCESS_HI_BANK, f};
      end
    end
    return r;
  endfunction

  function automatic flags_t neg_flags(input logic [7:0] v);
    flags_t  r;
    logic [7:0] n;
    n = (~v) + 8'h01;
    r.neg              = n[7];
    r.overflow_flag    = (v == 8'h80);
    r.carry            = (v == 8'h00);
    r.digit_carry_flag = (v[3:0] == 4'h0);
    r.zero             = (n == 8'h00);
    return r;
  endfunction

  assign take        = instr_valid && st_ff.ready;
  assign stk_wr      = (st_ff.phase == PH_READ) && (st_ff.op == OP_PUSH)
                       && (st_ff.sp != STACK_FULL);
  assign stk_rd_addr = st_ff.sp - 5'h01;

  always_comb begin
    product = 16'h0000;
    if (st_ff.op == OP_MULL) begin
      product = {8'h00, st_ff.work} * {8'h00, st_ff.lit};
    end else begin
      product = {8'h00, st_ff.work} * {8'h00, file_rdata};
    end
  end

  return_stack_mem u_stack (
    .clk     (clk),
    .wr_en   (stk_wr),
    .wr_addr (st_ff.sp),
    .wr_data (st_ff.top_of_stack),
    .rd_addr (stk_rd_addr),
    .rd_data (stk_rd_data)
  );

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.done     = 1'b0;
    nxt_st.flags_wr = 1'b0;
    nxt_st.file.rd  = 1'b0;
    nxt_st.file.wr  = 1'b0;
    case (st_ff.phase)
      PH_IDLE, PH_WRITE: begin
        if (st_ff.phase == PH_WRITE) begin
          nxt_st.done = 1'b1;
        end
        if (take) begin
          nxt_st.phase     = PH_DECODE;
          nxt_st.op        = classify(instr_word);
          nxt_st.lit       = instr_word[7:0];
          nxt_st.work      = work_reg;
          nxt_st.push_val  = pc + PC_STEP;
          nxt_st.file.addr = map_addr(instr_word[8], instr_word[7:0],
                                      bank_select_register, ext_set_en, index_base);
          nxt_st.indexed   = !instr_word[8] && ext_set_en
                             && (instr_word[7:0] <= INDEXED_LIMIT);
          nxt_st.ready     = 1'b0;
        end else begin
          nxt_st.phase = PH_IDLE;
          nxt_st.ready = 1'b1;
        end
      end
      PH_DECODE: begin
        nxt_st.phase   = PH_READ;
        nxt_st.file.rd = (st_ff.op == OP_MULF) || (st_ff.op == OP_NEG);
      end
      PH_READ: begin
        nxt_st.phase = PH_PROCESS;
        if (st_ff.op == OP_PUSH) begin
          if (st_ff.sp != STACK_FULL) begin
            nxt_st.top_of_stack = st_ff.push_val;
            nxt_st.sp           = st_ff.sp + 5'h01;
          end else begin
            nxt_st.stack_ovf = 1'b1;
          end
        end
      end
      PH_PROCESS: begin
        nxt_st.phase = PH_WRITE;
        nxt_st.ready = 1'b1;
        case (st_ff.op)
          OP_STORE: begin
            nxt_st.file.wr    = 1'b1;
            nxt_st.file.wdata = st_ff.work;
          end
          OP_MULL, OP_MULF: begin
            nxt_st.product_high = product[15:8];
            nxt_st.product_low  = product[7:0];
          end
          OP_NEG: begin
            nxt_st.file.wr    = 1'b1;
            nxt_st.file.wdata = (~file_rdata) + 8'h01;
            nxt_st.flags      = neg_flags(file_rdata);
            nxt_st.flags_wr   = 1'b1;
          end
          OP_POP: begin
            if (st_ff.sp != SP_RESET) begin
              nxt_st.top_of_stack = stk_rd_data;
              nxt_st.sp           = st_ff.sp - 5'h01;
            end else begin
              nxt_st.top_of_stack = TOP_RESET;
              nxt_st.stack_unf    = 1'b1;
            end
          end
          default: begin
            nxt_st.phase = PH_WRITE;
          end
        endcase
      end
      default: begin
        nxt_st.phase = PH_IDLE;
        nxt_st.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{phase: PH_IDLE, op: OP_NOP, lit: 8'h00, work: 8'h00, indexed: 1'b0,
                 file: '{addr: ADDR_RESET, rd: 1'b0, wr: 1'b0, wdata: 8'h00},
                 product_high: PROD_RESET, product_low: PROD_RESET,
                 flags: '0, flags_wr: 1'b0, push_val: TOP_RESET,
                 top_of_stack: TOP_RESET, sp: SP_RESET, stack_ovf: 1'b0,
                 stack_unf: 1'b0, ready: 1'b1, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ready           = st_ff.ready;
  assign done            = st_ff.done;
  assign file_addr       = st_ff.file.addr;
  assign file_rd         = st_ff.file.rd;
  assign file_wr         = st_ff.file.wr;
  assign file_wdata      = st_ff.file.wdata;
  assign indexed_mode    = st_ff.indexed;
  assign product_high    = st_ff.product_high;
  assign product_low     = st_ff.product_low;
  assign flags           = st_ff.flags;
  assign flags_wr        = st_ff.flags_wr;
  assign top_of_stack    = st_ff.top_of_stack;
  assign stack_ptr       = st_ff.sp;
  assign stack_overflow  = st_ff.stack_ovf;
  assign stack_underflow = st_ff.stack_unf;

endmodule
`default_nettype wire

// ---- hw/cpu_ops_pkg.sv ----
// Shared types and constants for the multiply, negate and stack instruction group
package cpu_ops_pkg;

  // Instruction word patterns
  localparam logic [6:0]  OPC_STORE_HI   = 7'h37;   // 0110 111a
  localparam logic [6:0]  OPC_NEG_HI     = 7'h36;   // 0110 110a
  localparam logic [6:0]  OPC_MULF_HI    = 7'h01;   // 0000 001a
  localparam logic [7:0]  OPC_MULL_HI    = 8'h0d;   // 0000 1101
  localparam logic [15:0] OPC_POP        = 16'h0006;
  localparam logic [15:0] OPC_PUSH       = 16'h0005;
  localparam logic [15:0] OPC_NOP        = 16'h0000;
  localparam logic [3:0]  OPC_NOP_ALT    = 4'hf;

  // Addressing
  localparam logic [7:0]  INDEXED_LIMIT  = 8'h5f;   // Offsets 0..95 are indexed
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;   // Access bank split, legacy set
  localparam logic [7:0]  ACCESS_SPLIT_X = 8'h60;   // Access bank split, extended set
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;

  // Return stack
  localparam int          STACK_LEVELS   = 31;
  localparam logic [4:0]  STACK_FULL     = 5'h1f;
  localparam logic [4:0]  SP_RESET       = 5'h00;
  localparam logic [20:0] TOP_RESET      = 21'h000000;
  localparam logic [20:0] PC_STEP        = 21'h000002;

  // Reset values
  localparam logic [7:0]  PROD_RESET     = 8'h00;
  localparam logic [11:0] ADDR_RESET     = 12'h000;

  typedef enum logic [4:0] {
    PH_IDLE    = 5'b00001,
    PH_DECODE  = 5'b00010,
    PH_READ    = 5'b00100,
    PH_PROCESS = 5'b01000,
    PH_WRITE   = 5'b10000
  } phase_t;

  typedef enum logic [2:0] {
    OP_NOP   = 3'h0,
    OP_STORE = 3'h1,
    OP_MULL  = 3'h2,
    OP_MULF  = 3'h3,
    OP_NEG   = 3'h4,
    OP_POP   = 3'h5,
    OP_PUSH  = 3'h6
  } op_t;

  typedef struct packed {
    logic neg;
    logic overflow_flag;
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } flags_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } file_port_t;

  typedef struct packed {
    phase_t      phase;
    op_t         op;
    logic [7:0]  lit;
    logic [7:0]  work;
    logic        indexed;
    file_port_t  file;
    logic [7:0]  product_high;
    logic [7:0]  product_low;
    flags_t      flags;
    logic        flags_wr;
    logic [20:0] push_val;
    logic [20:0] top_of_stack;
    logic [4:0]  sp;
    logic        stack_ovf;
    logic        stack_unf;
    logic        ready;
    logic        done;
  } state_t;

endpackage

// ---- hw/return_stack_mem.sv ----
// Lower levels of the hardware return stack, registered read
`timescale 1ns/1ps
`default_nettype none
module return_stack_mem (
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [20:0] wr_data,
  input  wire logic [4:0]  rd_addr,
  output logic      [20:0] rd_data
);
  logic [20:0] mem [0:31];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ---- test/data_mem_model.sv ----
// Data memory partner: registered read, write on strobe
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
  input  wire logic        clk,
  input  wire logic [11:0] file_addr,
  input  wire logic        file_rd,
  input  wire logic        file_wr,
  input  wire logic [7:0]  file_wdata,
  output var  logic [7:0]  file_rdata
);
  logic [7:0] cells [4096];
  initial file_rdata = 8'h3c;
  always @(posedge clk) begin
    if (file_wr) cells[file_addr] <= file_wdata;
    // Idle read bus toggles so stale data never looks valid
    file_rdata <= file_rd ? cells[file_addr] : ~file_rdata;
  end
endmodule
`default_nettype wire

// ---- test/cpu_ops_asserts.sv ----
// Checker for the multiply, negate and stack instruction group
`timescale 1ns/1ps
`default_nettype none
module cpu_ops_asserts
  import cpu_ops_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       instr_valid,
  input wire logic       ready,
  input wire logic       done,
  input wire logic       file_rd,
  input wire logic       file_wr,
  input wire logic [7:0] file_wdata,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] product_high,
  input wire logic [7:0] product_low,
  input wire flags_t     flags,
  input wire logic       flags_wr,
  input wire logic [4:0] stack_ptr,
  input wire logic       stack_overflow
);
  logic       take;
  logic       rdq_ff;
  logic [7:0] rd_ff;
  assign take = instr_valid && ready;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdq_ff <= 1'b0;
      rd_ff <= 8'h00;
    end else begin
      rdq_ff <= file_rd;
      if (rdq_ff) rd_ff <= file_rdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ready_gap_a: assert property (take |=> !ready [*3] ##[1:2] ready)
    else $error("ready gap after take wrong");
  done_bound_a: assert property (take |-> ##[4:6] done)
    else $error("no done after take");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  wr_done_a: assert property (file_wr |=> done)
    else $error("write not followed by done");
  neg_result_a: assert property (flags_wr |-> file_wr && file_wdata == (~rd_ff + 8'h01))
    else $error("negate result wrong");
  neg_flags_a: assert property (flags_wr |-> flags == {file_wdata[7], rd_ff == 8'h80,
    rd_ff == 8'h00, rd_ff[3:0] == 4'h0, file_wdata == 8'h00})
    else $error("negate flags wrong");
  flags_only_neg_a: assert property ($changed(flags) |-> flags_wr)
    else $error("flags changed without negate");
  prod_done_a: assert property ($changed({product_high, product_low}) |=> done)
    else $error("product changed outside write phase");
  sp_step_a: assert property ($changed(stack_ptr) |-> (stack_ptr == $past(stack_ptr) + 5'h01)
    || (stack_ptr == $past(stack_ptr) - 5'h01))
    else $error("stack pointer jumped");
  cover property (flags_wr);
  cover property ($rose(stack_overflow));
  cover property ($changed(product_low));
endmodule
`default_nettype wire

// ---- test/tb_cpu_mul_neg_stack_ops.sv ----
// Self-checking bench for the multiply, negate and stack instruction group
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_mul_neg_stack_ops
  import cpu_ops_pkg::*;
;
  typedef struct packed {
    logic [15:0] prod;
    logic [20:0] top;
    logic [4:0]  sp;
    flags_t      fl;
    logic [11:0] addr;
    logic [7:0]  mem;
  } note_t;
  logic        clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, ext_set_en = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [20:0] pc = 21'h000000;
  logic [7:0]  work_reg = 8'h00, bank_select_register = 8'h00;
  logic [11:0] index_base = 12'h000;
  logic        ready, done, file_rd, file_wr, indexed_mode, flags_wr;
  logic        stack_overflow, stack_underflow;
  logic [7:0]  file_rdata, file_wdata, product_high, product_low;
  logic [11:0] file_addr;
  flags_t      flags;
  logic [20:0] top_of_stack;
  logic [4:0]  stack_ptr;
  logic [7:0]  sh [4096];
  logic [20:0] stk [32];
  note_t       e, n;
  note_t       notes [$];
  int          n_errors = 0, num_checks = 0, cyc = 0;
  cpu_mul_neg_stack_ops dut (.clk, .rst, .instr_valid, .instr_word, .pc, .work_reg,
    .bank_select_register, .index_base, .ext_set_en, .file_rdata, .ready, .done,
    .file_addr, .file_rd, .file_wr, .file_wdata, .indexed_mode, .product_high,
    .product_low, .flags, .flags_wr, .top_of_stack, .stack_ptr, .stack_overflow,
    .stack_underflow);
  data_mem_model partner (.clk, .file_addr, .file_rd, .file_wr, .file_wdata, .file_rdata);
  initial forever #5 clk = ~clk;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [11:0] ea(input logic [7:0] f, input logic a);
    if (a) return {bank_select_register[3:0], f};
    if (ext_set_en && f <= INDEXED_LIMIT) return index_base + 12'(f);
    return {(f < (ext_set_en ? ACCESS_SPLIT_X : ACCESS_SPLIT)) ? ACCESS_LO_BANK
      : ACCESS_HI_BANK, f};
  endfunction
  task automatic issue(input int k, input logic [7:0] f, input logic a);
    logic [15:0] w16;
    logic [11:0] ad;
    logic [7:0]  v;
    logic        idx;
    ad = ea(f, a);
    idx = !a && ext_set_en && (f <= INDEXED_LIMIT);
    v = sh[ad];
    case (k)
      0: begin w16 = {OPC_STORE_HI, a, f}; sh[ad] = work_reg; end
      1: begin
        w16 = {OPC_NEG_HI, a, f};
        sh[ad] = ~v + 8'h01;
        e.fl = {sh[ad][7], v == 8'h80, v == 8'h00, v[3:0] == 4'h0, sh[ad] == 8'h00};
      end
      2: begin w16 = {OPC_MULF_HI, a, f}; e.prod = work_reg * v; end
      3: begin w16 = {OPC_MULL_HI, f}; e.prod = work_reg * f; end
      4: begin
        w16 = OPC_POP;
        if (e.sp == SP_RESET) e.top = TOP_RESET;
        else begin e.sp--; e.top = stk[e.sp]; end
      end
      5: begin
        w16 = OPC_PUSH;
        if (e.sp != STACK_FULL) begin stk[e.sp] = e.top; e.top = pc + PC_STEP; e.sp++; end
      end
      6: w16 = OPC_NOP;
      default: w16 = {OPC_NOP_ALT, 4'h0, f};
    endcase
    e.addr = ad;
    e.mem = sh[ad];
    notes.push_back(e);
    instr_word = w16;
    instr_valid = 1'b1;
    while (ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    if (k < 3) chk({file_addr, indexed_mode}, {ad, idx}, "address");
  endtask
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) chk(80'h1, 80'h0, "done without take");
      else begin
        n = notes.pop_front();
        chk({product_high, product_low, top_of_stack, stack_ptr, flags},
          {n.prod, n.top, n.sp, n.fl}, "state");
        chk(partner.cells[n.addr], n.mem, "memory");
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin n_errors++; $display("timeout"); tally_and_finish(); end
  end
  initial begin
    logic [7:0] f;
    e = '0;
    f = 8'($urandom(32'h10d3f997));
    for (int i = 0; i < 4096; i++) begin sh[i] = 8'($urandom); partner.cells[i] = sh[i]; end
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk({ready, done, file_wr, stack_ptr}, {3'b100, 5'h00}, "reset");
    $display("test reset done");
    for (int i = 0; i < 400; i++) begin
      case ($urandom_range(4))
        0: f = INDEXED_LIMIT;
        1: f = 8'h60;
        2: f = 8'h7f;
        3: f = 8'h80;
        default: f = 8'($urandom);
      endcase
      work_reg = 8'($urandom);
      pc = 21'($urandom) & 21'h1ffffe;
      bank_select_register = 8'($urandom);
      index_base = 12'($urandom);
      ext_set_en = 1'($urandom);
      issue(i % 8, f, 1'($urandom));
    end
    $display("test random mix done");
    for (int i = 0; i < 34; i++) begin pc = 21'(i * 4); issue(5, 8'h00, 1'b1); end
    for (int i = 0; i < 34; i++) issue(4, 8'h00, 1'b1);
    instr_valid = 1'b0;
    repeat (8) @(negedge clk);
    chk({notes.size(), stack_overflow, stack_underflow}, {32'd0, 2'b11}, "stack limits");
    $display("test stack limits done");
    tally_and_finish();
  end
endmodule
bind cpu_mul_neg_stack_ops cpu_ops_asserts chk_i (.clk(clk), .rst(rst),
  .instr_valid(instr_valid), .ready(ready), .done(done), .file_rd(file_rd),
  .file_wr(file_wr), .file_wdata(file_wdata), .file_rdata(file_rdata),
  .product_high(product_high), .product_low(product_low), .flags(flags),
  .flags_wr(flags_wr), .stack_ptr(stack_ptr), .stack_overflow(stack_overflow));
`default_nettype wire
